/* File: include/iap_flash_pkg.sv */
package iap_flash_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS    = 8;
  localparam int ERASE_SHORT_NS   = 3200000;
  localparam int WRITE_SHORT_NS   = 2200000;
  localparam int ERASE_LONG_NS    = 3700000;
  localparam int WRITE_LONG_NS    = 3000000;
  localparam int UNLOCK_WINDOW_NS = 8192;
  localparam int READ_NS          = 32;
  localparam int ERASE_SHORT_CYC  = ERASE_SHORT_NS / CLK_PERIOD_NS;
  localparam int WRITE_SHORT_CYC  = WRITE_SHORT_NS / CLK_PERIOD_NS;
  localparam int ERASE_LONG_CYC   = ERASE_LONG_NS / CLK_PERIOD_NS;
  localparam int WRITE_LONG_CYC   = WRITE_LONG_NS / CLK_PERIOD_NS;
  localparam int UNLOCK_CYC       = UNLOCK_WINDOW_NS / CLK_PERIOD_NS;
  localparam int READ_CYC         = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W            = 20;

  // ****************************************
  // Register indices (sector 0 direct, sector 1 extended)
  // ****************************************
  localparam logic       SECTOR_DIRECT   = 1'b0;
  localparam logic       SECTOR_EXTENDED = 1'b1;
  localparam logic [3:0] IDX_ADDR_LOW    = 4'h0;
  localparam logic [3:0] IDX_ADDR_HIGH   = 4'h1;
  localparam logic [3:0] IDX_DATA0_LOW   = 4'h2;
  localparam logic [3:0] IDX_DATA0_HIGH  = 4'h3;
  localparam logic [3:0] IDX_CTRL_MAIN   = 4'h0;
  localparam logic [3:0] IDX_CHIP_RESET  = 4'h1;
  localparam logic [3:0] IDX_BUF_TIMING  = 4'h2;

  // ****************************************
  // Fields and values
  // ****************************************
  localparam int         EWEN_BIT    = 7;
  localparam int         MODE_LSB    = 4;
  localparam int         UNLOCK_BIT  = 3;
  localparam int         WT_BIT      = 2;
  localparam int         RDEN_BIT    = 1;
  localparam int         RD_BIT      = 0;
  localparam int         BUFFER_CLEAR_TRIGGER_BIT    = 0;
  localparam int         TSEL_BIT    = 1;
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [4:0] PAGE_LAST   = 5'h1F;
  localparam logic [7:0] CHIP_RST_KEY = 8'h55;
  localparam logic [7:0] KEY_D1L     = 8'h00;
  localparam logic [7:0] KEY_D2L     = 8'h0D;
  localparam logic [7:0] KEY_D3L     = 8'hC3;
  localparam logic [7:0] KEY_D1H     = 8'h04;
  localparam logic [7:0] KEY_D2H     = 8'h09;
  localparam logic [7:0] KEY_D3H     = 8'h40;

  typedef enum logic [2:0] {
    MODE_WRITE  = 3'b000,
    MODE_ERASE  = 3'b001,
    MODE_READ   = 3'b011,
    MODE_UNLOCK = 3'b110
  } op_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ERASE = 2'b01,
    ST_WRITE = 2'b10,
    ST_READ  = 2'b11
  } op_state_t;

endpackage

/* File: hw/iap_flash_program_control.sv */
`timescale 1ns/1ps

// Functional notes
// - Word address is 14 bits; high address byte bits 7:6 read zero.
// - Four 16-bit data words, two address and three control registers reset zero.
// - Address/data in direct sector; control registers in extended sector.
// - Low byte write of word 0 stores only, no buffer load.
// - High byte write of word 0 loads buffer when enable flag is set, then increments address.
// - Enable flag set only by hardware; software may only clear it.
// - Enable flag one means erase and write permitted.
// - Mode 000 write, 001 erase, 011 read, 110 unlock; others reserved.
// - Unlock trigger starts timer; hardware clears trigger at timeout.
// - Write trigger starts erase/write, cleared by hardware when done.
// - Read starts only while read enable is high.
// - Read trigger starts word read, cleared by hardware when done.
// - CPU is halted while an operation runs.
// - Auto-increment stops at the last word of the 32-word page.
// - Buffer clear bit clears the buffer, then hardware returns it low.
// - Timing select picks 3.2/2.2 ms or 3.7/3.0 ms erase/write.
module iap_flash_program_control #(
  parameter int unsigned ERASE_SHORT_CYC = iap_flash_pkg::ERASE_SHORT_CYC,
  parameter int unsigned WRITE_SHORT_CYC = iap_flash_pkg::WRITE_SHORT_CYC,
  parameter int unsigned ERASE_LONG_CYC  = iap_flash_pkg::ERASE_LONG_CYC,
  parameter int unsigned WRITE_LONG_CYC  = iap_flash_pkg::WRITE_LONG_CYC
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // Special register access
  input  wire logic        sfr_wr_i,
  input  wire logic        sfr_rd_i,
  input  wire logic        sfr_sector_i,
  input  wire logic [3:0]  sfr_idx_i,
  input  wire logic [7:0]  sfr_wdata_i,
  output logic      [7:0]  sfr_rdata_o,
  // Flash array and write buffer
  output logic      [13:0] flash_word_address_o,
  output logic             buf_load_o,
  output logic      [4:0]  buf_word_o,
  output logic      [15:0] buf_data_o,
  output logic             buf_clear_o,
  output logic             page_erase_o,
  output logic             page_write_o,
  output logic             word_read_o,
  input  wire logic [15:0] flash_rdata_i,
  // System
  output logic             cpu_stall_o,
  output logic             chip_reset_o
);

  // ****************************************
  // State
  // ****************************************
  logic [13:0]                    addr_q;
  logic [15:0]                    data_q [4];
  logic                           ewen_q;
  logic [2:0]                     mode_q;
  logic                           unlock_q;
  logic                           wt_q;
  logic                           rden_q;
  logic                           rd_q;
  logic [7:0]                     chiprst_q;
  logic                           tsel_q;
  logic                           buffer_clear_trigger_q;
  logic [iap_flash_pkg::CNT_W-1:0] ucnt_q;
  logic [iap_flash_pkg::CNT_W-1:0] cnt_q;
  iap_flash_pkg::op_state_t       state_q;
  logic [7:0]                     rdata_q;
  logic                           buf_load_q;
  logic [4:0]                     buf_word_q;
  logic [15:0]                    buf_data_q;
  logic                           buf_clear_q;
  logic                           erase_q;
  logic                           write_q;
  logic                           read_q;
  logic                           stall_q;
  logic                           chip_reset_q;

  // Register write decode, shared by every register process
  function automatic logic wr_hit(input logic sec, input logic [3:0] idx);
    return sfr_wr_i && (sfr_sector_i == sec) && (sfr_idx_i == idx);
  endfunction

  // ****************************************
  // Decode and sequencing terms
  // ****************************************
  logic wr_ctrl;
  logic wr_d0h;
  logic idle;
  logic fin;
  logic start_erase;
  logic start_write;
  logic start_read;
  logic reject_wt;
  logic reject_rd;
  logic wt_clr;
  logic rd_clr;
  logic unlock_set;
  logic unlock_expire;
  logic key_ok;
  logic unlock_ok;
  logic [iap_flash_pkg::CNT_W-1:0] erase_cyc;
  logic [iap_flash_pkg::CNT_W-1:0] write_cyc;

  // Start, refusal and completion conditions
  always_comb begin
    wr_ctrl     = wr_hit(iap_flash_pkg::SECTOR_EXTENDED, iap_flash_pkg::IDX_CTRL_MAIN);
    wr_d0h      = wr_hit(iap_flash_pkg::SECTOR_DIRECT, iap_flash_pkg::IDX_DATA0_HIGH);
    idle        = (state_q == iap_flash_pkg::ST_IDLE);
    fin         = !idle && (cnt_q == iap_flash_pkg::CNT_W'(1));
    // Erase and write need the enable flag; write trigger beats read trigger
    start_erase = idle && wt_q && ewen_q && (mode_q == iap_flash_pkg::MODE_ERASE);
    start_write = idle && wt_q && ewen_q && (mode_q == iap_flash_pkg::MODE_WRITE);
    reject_wt   = idle && wt_q && !start_erase && !start_write;
    start_read  = idle && !wt_q && rd_q && rden_q
                  && (mode_q == iap_flash_pkg::MODE_READ);
    reject_rd   = idle && !wt_q && rd_q && !start_read;
    wt_clr      = reject_wt || (fin && (state_q != iap_flash_pkg::ST_READ));
    rd_clr      = reject_rd || (fin && (state_q == iap_flash_pkg::ST_READ));
    // A retrigger while the window runs is ignored, it does not restart
    unlock_set    = wr_ctrl && sfr_wdata_i[iap_flash_pkg::UNLOCK_BIT] && !unlock_q;
    unlock_expire = unlock_q && (ucnt_q == iap_flash_pkg::CNT_W'(1));
    key_ok        = (data_q[1] == {iap_flash_pkg::KEY_D1H, iap_flash_pkg::KEY_D1L})
                    && (data_q[2] == {iap_flash_pkg::KEY_D2H, iap_flash_pkg::KEY_D2L})
                    && (data_q[3] == {iap_flash_pkg::KEY_D3H, iap_flash_pkg::KEY_D3L});
    unlock_ok     = unlock_expire && key_ok
                    && (mode_q == iap_flash_pkg::MODE_UNLOCK);
    erase_cyc = tsel_q ? iap_flash_pkg::CNT_W'(ERASE_LONG_CYC)
                       : iap_flash_pkg::CNT_W'(ERASE_SHORT_CYC);
    write_cyc = tsel_q ? iap_flash_pkg::CNT_W'(WRITE_LONG_CYC)
                       : iap_flash_pkg::CNT_W'(WRITE_SHORT_CYC);
  end

  // ****************************************
  // Main control register
  // ****************************************
  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ewen_q   <= 1'b0;
      mode_q   <= 3'b000;
      unlock_q <= 1'b0;
      wt_q     <= 1'b0;
      rden_q   <= 1'b0;
      rd_q     <= 1'b0;
    end else begin
      ewen_q   <= unlock_ok
                  || (ewen_q && !(wr_ctrl && !sfr_wdata_i[iap_flash_pkg::EWEN_BIT]));
      unlock_q <= unlock_set || (unlock_q && !unlock_expire);
      wt_q     <= (wr_ctrl && idle && sfr_wdata_i[iap_flash_pkg::WT_BIT])
                  || (wt_q && !wt_clr);
      rd_q     <= (wr_ctrl && idle && sfr_wdata_i[iap_flash_pkg::RD_BIT])
                  || (rd_q && !rd_clr);
      if (wr_ctrl) begin
        mode_q <= sfr_wdata_i[iap_flash_pkg::MODE_LSB +: 3];
        rden_q <= sfr_wdata_i[iap_flash_pkg::RDEN_BIT];
      end
    end
  end

  // Unlock window timer
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ucnt_q <= '0;
    end else if (unlock_set) begin
      ucnt_q <= iap_flash_pkg::CNT_W'(iap_flash_pkg::UNLOCK_CYC);
    end else if (ucnt_q != '0) begin
      ucnt_q <= ucnt_q - iap_flash_pkg::CNT_W'(1);
    end
  end

  // ****************************************
  // Address and data words
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      addr_q <= '0;
      for (int i = 0; i < 4; i++) begin
        data_q[i] <= '0;
      end
    end else begin
      if (wr_hit(iap_flash_pkg::SECTOR_DIRECT, iap_flash_pkg::IDX_ADDR_LOW)) begin
        addr_q[7:0] <= sfr_wdata_i;
      end
      if (wr_hit(iap_flash_pkg::SECTOR_DIRECT, iap_flash_pkg::IDX_ADDR_HIGH)) begin
        addr_q[13:8] <= sfr_wdata_i[5:0];
      end
      // Clamped at the page end so tagging never spills into the next page
      if (wr_d0h && (addr_q[4:0] != iap_flash_pkg::PAGE_LAST)) begin
        addr_q <= addr_q + 14'h0001;
      end
      for (int i = 0; i < 4; i++) begin
        if (wr_hit(iap_flash_pkg::SECTOR_DIRECT, 4'(2 * i + 2))) begin
          data_q[i][7:0] <= sfr_wdata_i;
        end
        if (wr_hit(iap_flash_pkg::SECTOR_DIRECT, 4'(2 * i + 3))) begin
          data_q[i][15:8] <= sfr_wdata_i;
        end
      end
      // Read result lands in word 0 for software to collect
      if (fin && (state_q == iap_flash_pkg::ST_READ)) begin
        data_q[0] <= flash_rdata_i;
      end
    end
  end

  // ****************************************
  // Write buffer, timing select and chip reset
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      buf_load_q   <= 1'b0;
      buf_word_q   <= '0;
      buf_data_q   <= '0;
      buf_clear_q  <= 1'b0;
      buffer_clear_trigger_q       <= 1'b0;
      tsel_q       <= 1'b0;
      chiprst_q    <= iap_flash_pkg::REG_RESET;
      chip_reset_q <= 1'b0;
    end else begin
      // Buffer only fills once erase/write is enabled
      buf_load_q <= wr_d0h && ewen_q;
      if (wr_d0h) begin
        buf_word_q <= addr_q[4:0];
        buf_data_q <= {sfr_wdata_i, data_q[0][7:0]};
      end
      // Clear pulses once per request; a finished page write also clears
      buf_clear_q <= buffer_clear_trigger_q || (fin && (state_q == iap_flash_pkg::ST_WRITE));
      buffer_clear_trigger_q      <= wr_hit(iap_flash_pkg::SECTOR_EXTENDED, iap_flash_pkg::IDX_BUF_TIMING)
                     && sfr_wdata_i[iap_flash_pkg::BUFFER_CLEAR_TRIGGER_BIT];
      if (wr_hit(iap_flash_pkg::SECTOR_EXTENDED, iap_flash_pkg::IDX_BUF_TIMING)) begin
        tsel_q <= sfr_wdata_i[iap_flash_pkg::TSEL_BIT];
      end
      if (wr_hit(iap_flash_pkg::SECTOR_EXTENDED, iap_flash_pkg::IDX_CHIP_RESET)) begin
        chiprst_q <= sfr_wdata_i;
      end
      chip_reset_q <= wr_hit(iap_flash_pkg::SECTOR_EXTENDED, iap_flash_pkg::IDX_CHIP_RESET)
                      && (sfr_wdata_i == iap_flash_pkg::CHIP_RST_KEY);
    end
  end

  // ****************************************
  // Operation sequencer
  // ****************************************
  // Output strobes follow the next state so they leave straight from flops
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= iap_flash_pkg::ST_IDLE;
      cnt_q   <= '0;
      erase_q <= 1'b0;
      write_q <= 1'b0;
      read_q  <= 1'b0;
      stall_q <= 1'b0;
    end else begin
      unique case (state_q)
        iap_flash_pkg::ST_IDLE: begin
          if (start_erase) begin
            state_q <= iap_flash_pkg::ST_ERASE;
            cnt_q   <= erase_cyc;
            erase_q <= 1'b1;
            stall_q <= 1'b1;
          end else if (start_write) begin
            state_q <= iap_flash_pkg::ST_WRITE;
            cnt_q   <= write_cyc;
            write_q <= 1'b1;
            stall_q <= 1'b1;
          end else if (start_read) begin
            state_q <= iap_flash_pkg::ST_READ;
            cnt_q   <= iap_flash_pkg::CNT_W'(iap_flash_pkg::READ_CYC);
            read_q  <= 1'b1;
            stall_q <= 1'b1;
          end
        end
        iap_flash_pkg::ST_ERASE, iap_flash_pkg::ST_WRITE, iap_flash_pkg::ST_READ: begin
          if (fin) begin
            state_q <= iap_flash_pkg::ST_IDLE;
            erase_q <= 1'b0;
            write_q <= 1'b0;
            read_q  <= 1'b0;
            stall_q <= 1'b0;
          end
          cnt_q <= cnt_q - iap_flash_pkg::CNT_W'(1);
        end
      endcase
    end
  end

  // ****************************************
  // Register readback
  // ****************************************
  // Data appears the cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_q <= iap_flash_pkg::REG_RESET;
    end else if (!sfr_rd_i) begin
      rdata_q <= iap_flash_pkg::REG_RESET;
    end else if (sfr_sector_i == iap_flash_pkg::SECTOR_EXTENDED) begin
      unique case (sfr_idx_i)
        iap_flash_pkg::IDX_CTRL_MAIN:  rdata_q <= {ewen_q, mode_q, unlock_q, wt_q, rden_q, rd_q};
        iap_flash_pkg::IDX_CHIP_RESET: rdata_q <= chiprst_q;
        iap_flash_pkg::IDX_BUF_TIMING: rdata_q <= {6'h00, tsel_q, buffer_clear_trigger_q};
        default:                       rdata_q <= iap_flash_pkg::REG_RESET;
      endcase
    end else if (sfr_idx_i == iap_flash_pkg::IDX_ADDR_LOW) begin
      rdata_q <= addr_q[7:0];
    end else if (sfr_idx_i == iap_flash_pkg::IDX_ADDR_HIGH) begin
      rdata_q <= {2'b00, addr_q[13:8]};
    end else if (sfr_idx_i >= iap_flash_pkg::IDX_DATA0_LOW && sfr_idx_i <= 4'h9) begin
      rdata_q <= sfr_idx_i[0] ? data_q[2'(sfr_idx_i[3:1] - 3'h1)][15:8]
                              : data_q[2'(sfr_idx_i[3:1] - 3'h1)][7:0];
    end else begin
      rdata_q <= iap_flash_pkg::REG_RESET;
    end
  end

  // Outputs
  assign sfr_rdata_o          = rdata_q;
  assign flash_word_address_o = addr_q;
  assign buf_load_o           = buf_load_q;
  assign buf_word_o           = buf_word_q;
  assign buf_data_o           = buf_data_q;
  assign buf_clear_o          = buf_clear_q;
  assign page_erase_o         = erase_q;
  assign page_write_o         = write_q;
  assign word_read_o          = read_q;
  assign cpu_stall_o          = stall_q;
  assign chip_reset_o         = chip_reset_q;

  // ****************************************
  // Checks
  // ****************************************
  chk_addr_high_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
    sfr_rd_i && !sfr_sector_i && sfr_idx_i == iap_flash_pkg::IDX_ADDR_HIGH
    |=> sfr_rdata_o[7:6] == 2'b00 && sfr_rdata_o[5:0] == $past(addr_q[13:8]))
    else $error("high address readback wrong");
  chk_reset_zero: assert property (@(posedge core_clk_i)
    $fell(rst_i) |-> addr_q == 14'h0000 && !ewen_q && !wt_q && !rd_q && !stall_q)
    else $error("state not cleared by reset");
  chk_low_no_load: assert property (@(posedge core_clk_i) disable iff (rst_i)
    sfr_wr_i && !sfr_sector_i && sfr_idx_i == iap_flash_pkg::IDX_DATA0_LOW
    |=> !buf_load_o && addr_q == $past(addr_q))
    else $error("low byte write touched buffer or address");
  chk_high_increment: assert property (@(posedge core_clk_i) disable iff (rst_i)
    wr_d0h && ewen_q && addr_q[4:0] != 5'h1F
    |=> buf_load_o && addr_q == $past(addr_q) + 14'h0001 && buf_word_o == $past(addr_q[4:0]))
    else $error("high byte write did not load and increment");
  chk_page_clamp: assert property (@(posedge core_clk_i) disable iff (rst_i)
    wr_d0h && addr_q[4:0] == 5'h1F |=> addr_q == $past(addr_q))
    else $error("address crossed page end");
  chk_enable_hw_only: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(ewen_q) |-> $past(unlock_expire) && $past(key_ok))
    else $error("enable flag set without unlock");
  chk_unlock_timeout: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(unlock_q) |-> unlock_q [*8])
    else $error("unlock trigger dropped early");
  chk_unlock_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
    unlock_q && ucnt_q == 20'h00001 |=> !unlock_q)
    else $error("unlock trigger not cleared at timeout");
  chk_erase_start: assert property (@(posedge core_clk_i) disable iff (rst_i)
    idle && wt_q && ewen_q && mode_q == 3'b001
    |=> page_erase_o && cpu_stall_o && cnt_q == $past(erase_cyc))
    else $error("erase did not start");
  chk_read_inhibit: assert property (@(posedge core_clk_i) disable iff (rst_i)
    idle && !wt_q && rd_q && !rden_q |=> !word_read_o && !rd_q)
    else $error("read ran while disabled");
  chk_read_done: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(word_read_o) |-> rd_q ##4 !word_read_o && !rd_q)
    else $error("read did not finish in time");
  chk_reserved_mode: assert property (@(posedge core_clk_i) disable iff (rst_i)
    idle && wt_q && (mode_q == 3'b010 || mode_q == 3'b111)
    |=> !wt_q && !page_erase_o && !page_write_o)
    else $error("reserved mode started an operation");
  chk_cpu_stall: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cpu_stall_o == (page_erase_o || page_write_o || word_read_o))
    else $error("stall not matching operation");
  chk_buffer_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
    buffer_clear_trigger_q |=> buf_clear_o && !buffer_clear_trigger_q)
    else $error("buffer clear not issued");

endmodule // iap_flash_program_control

/* File: sim/flash_array_model.sv */
`timescale 1ns/1ps
// ********************
// Flash array stand-in
// ********************
module flash_array_model (
  // Clock
  input  wire logic        core_clk_i,
  // Array side of the controller
  input  wire logic        read_i,
  input  wire logic [13:0] addr_i,
  output logic      [15:0] rdata_o
);
  logic [15:0] last_q = 16'h0000;
  // Remember the last word driven during a read
  always_ff @(posedge core_clk_i) begin
    if (read_i) begin
      last_q <= rdata_o;
    end
  end
  // Word derived from the address; the inverse of the last word outside a read,
  // so a stale word is never mistaken for a fresh one
  assign rdata_o = read_i ? {2'b10, addr_i} : ~last_q;
endmodule // flash_array_model

/* File: sim/tb.sv */
`timescale 1ns/1ps
// ********************
// Bench top
// ********************
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic        sec = 1'b0;
  logic [3:0]  idx = 4'h0;
  logic [7:0]  wd = 8'h00;
  logic [7:0]  rdata;
  logic [13:0] addr;
  logic [15:0] fdata, bdata, last_data;
  logic [4:0]  bword, last_word;
  logic        load, bclr, ers, pwr, rdop, stall, crst;
  int          bad_count = 0;
  int          n_tests = 0;
  int          loads = 0;
  int          clears = 0;
  int          resets = 0;
  int          ers_n = 0;
  int          pwr_n = 0;
  int          rdop_n = 0;
  int          cnt;
  logic [7:0]  key_v [6] = '{8'h00, 8'h0D, 8'hC3, 8'h04, 8'h09, 8'h40};
  logic [3:0]  key_i [6] = '{4'h4, 4'h6, 4'h8, 4'h5, 4'h7, 4'h9};

  // Short counts keep the run brief
  iap_flash_program_control #(.ERASE_SHORT_CYC(20), .WRITE_SHORT_CYC(16),
    .ERASE_LONG_CYC(30), .WRITE_LONG_CYC(24)) DUT (
    .core_clk_i(clk), .rst_i(rst), .sfr_wr_i(wr_s), .sfr_rd_i(rd_s), .sfr_sector_i(sec),
    .sfr_idx_i(idx), .sfr_wdata_i(wd), .sfr_rdata_o(rdata), .flash_word_address_o(addr),
    .buf_load_o(load), .buf_word_o(bword), .buf_data_o(bdata), .buf_clear_o(bclr),
    .page_erase_o(ers), .page_write_o(pwr), .word_read_o(rdop), .flash_rdata_i(fdata),
    .cpu_stall_o(stall), .chip_reset_o(crst));
  flash_array_model model (.core_clk_i(clk), .read_i(rdop), .addr_i(addr), .rdata_o(fdata));

  // Clock, 8 ns period
  initial begin
    forever #4 clk = ~clk;
  end
  // Pulses and strobe cycles are caught mid-cycle, where outputs have settled
  always @(negedge clk) begin
    if (load === 1'b1) begin
      loads++;
      last_data = bdata;
      last_word = bword;
    end
    if (bclr === 1'b1) clears++;
    if (crst === 1'b1) resets++;
    if (ers === 1'b1) ers_n++;
    if (pwr === 1'b1) pwr_n++;
    if (rdop === 1'b1) rdop_n++;
  end

  // ********************
  // Tasks
  // ********************
  task automatic conclude();
    if (bad_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One idle cycle after each strobe, so a strobe is never driven twice in a step
  task automatic wr(input logic s, input logic [3:0] i, input logic [7:0] d);
    sec <= s;
    idx <= i;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic s, input logic [3:0] i, input logic [7:0] e);
    sec <= s;
    idx <= i;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, e});
    @(posedge clk);
  endtask
  // Starts an operation and counts stall cycles; refused starts show none
  task automatic op(input logic [7:0] c, input int e);
    int k;
    cnt = 0;
    wr(1'b1, 4'h0, c);
    for (k = 0; k < 3000; k++) begin
      #1;
      if (stall === 1'b1) cnt++;
      else if (cnt > 0 || k > 4) break;
      @(posedge clk);
    end
    if (k == 3000) begin
      bad_count++;
      conclude();
    end
    @(posedge clk);
    chk(cnt, e);
  endtask

  // ********************
  // Sequence
  // ********************
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 10; i++) rd(1'b0, i[3:0], 8'h00);
    for (int i = 0; i < 3; i++) rd(1'b1, i[3:0], 8'h00);
    wr(1'b0, 4'h1, 8'hFF);
    rd(1'b0, 4'h1, 8'h3F);
    wr(1'b1, 4'h0, 8'h80);
    rd(1'b1, 4'h0, 8'h00);
    wr(1'b0, 4'h1, 8'h00);
    wr(1'b0, 4'h0, 8'h1E);
    wr(1'b0, 4'h2, 8'h34);
    chk(addr, 14'h001E);
    wr(1'b0, 4'h3, 8'h12);
    wr(1'b0, 4'h3, 8'h12);
    rd(1'b0, 4'h0, 8'h1F);
    rd(1'b0, 4'h2, 8'h34);
    chk(loads, 0);
    op(8'h04, 0);
    op(8'h24, 0);
    rd(1'b1, 4'h0, 8'h20);
    wr(1'b1, 4'h0, 8'h68);
    for (int i = 0; i < 6; i++) wr(1'b0, key_i[i], key_v[i]);
    repeat (1030) @(posedge clk);
    rd(1'b1, 4'h0, 8'hE0);
    op(8'hA4, 0);
    chk(ers_n, 0);
    op(8'h94, 20);
    chk(ers_n, 20);
    rd(1'b1, 4'h0, 8'h90);
    wr(1'b0, 4'h0, 8'h40);
    wr(1'b0, 4'h2, 8'hCD);
    wr(1'b0, 4'h3, 8'hAB);
    chk(loads, 1);
    chk(last_data, 16'hABCD);
    chk({11'h000, last_word}, 16'h0000);
    rd(1'b0, 4'h0, 8'h41);
    wr(1'b1, 4'h2, 8'h02);
    op(8'h84, 24);
    chk(pwr_n, 24);
    chk(clears, 1);
    op(8'h94, 30);
    chk(ers_n, 50);
    wr(1'b1, 4'h2, 8'h03);
    rd(1'b1, 4'h2, 8'h02);
    chk(clears, 2);
    op(8'hB1, 0);
    chk(rdop_n, 0);
    wr(1'b1, 4'h0, 8'hB2);
    op(8'hB3, 4);
    chk(rdop_n, 4);
    rd(1'b0, 4'h2, 8'h41);
    rd(1'b0, 4'h3, 8'h80);
    wr(1'b1, 4'h0, 8'h00);
    rd(1'b1, 4'h0, 8'h00);
    op(8'h04, 0);
    chk(pwr_n, 24);
    wr(1'b1, 4'h1, 8'h55);
    rd(1'b1, 4'h1, 8'h55);
    chk(resets, 1);
    conclude();
  end
endmodule // tb
